/* hw/dppi_consts.svh */
// Constants for the dual port pixel input: widths, timing counts.
// Assumes inclusion by package and design files alike.
`ifndef DPPI_CONSTS_SVH
`define DPPI_CONSTS_SVH
`define DPPI_COLOR_W 8
`define DPPI_COLOR_MSB 7
`define DPPI_COLOR_LSB 0
`define DPPI_PAIR_W 48
`define DPPI_FIFO_DEPTH 8
`define DPPI_LINE_ACTIVE_CLK 640
`define DPPI_LINE_MIN_CLK 660
`define DPPI_LINE_MAX_CLK 1024
`define DPPI_FRAME_ACTIVE_LINES 1024
`define DPPI_FRAME_MIN_LINES 1030
`define DPPI_FRAME_MAX_LINES 1422
`endif

/* hw/dppi_pkg.sv */
// Types shared by the dual port pixel input design.
// Assumes dppi_consts.svh alongside.
`include "dppi_consts.svh"
package dppi_pkg;
  typedef logic [`DPPI_COLOR_W-1:0] dppi_color_type;
  typedef logic [`DPPI_PAIR_W-1:0] dppi_pair_type;
  typedef enum logic [2:0] {
    dppi_st_idle = 3'h1,
    dppi_st_line = 3'h2,
    dppi_st_blank = 3'h4
  } dppi_state_type;
endpackage : dppi_pkg

/* hw/dppi_fifo.sv */
// Small FIFO holding pixel pairs, width and depth as parameters.
// Assumes one clock and synchronous active-high reset; read data registered.
`timescale 1ns/1ns
module dppi_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic [WIDTH-1:0] dout_q, dout_d;
  logic ov_q, ov_d;
  logic push, pop;
  always_comb begin
    // Output register counts as one slot outside the memory
    push = in_valid && (cnt_q != (AW+1)'(DEPTH));
    pop = (cnt_q != '0) && (!ov_q || out_ready);
    wr_d = push ? wr_q + AW'(1) : wr_q;
    rd_d = pop ? rd_q + AW'(1) : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    dout_d = pop ? mem_q[rd_q] : dout_q;
    ov_d = pop ? 1'b1 : (out_ready ? 1'b0 : ov_q);
  end
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
    if (reset) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      dout_q <= '0;
      ov_q <= 1'b0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      dout_q <= dout_d;
      ov_q <= ov_d;
    end
  end
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = ov_q;
  assign out_data = dout_q;
endmodule : dppi_fifo

/* hw/dppi_input.sv */
// Dual port pixel input: samples odd/even colour ports on the pixel link clock.
// Assumes link pins are asynchronous to clk_sys and slower than half its rate.
`timescale 1ns/1ns
`include "dppi_consts.svh"
module dppi_input (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic pixel_clock,
  input wire logic pixel_window_strobe,
  input wire dppi_pkg::dppi_color_type odd_red_bits,
  input wire dppi_pkg::dppi_color_type odd_green_bits,
  input wire dppi_pkg::dppi_color_type odd_blue_bits,
  input wire dppi_pkg::dppi_color_type even_red_bits,
  input wire dppi_pkg::dppi_color_type even_green_bits,
  input wire dppi_pkg::dppi_color_type even_blue_bits,
  output logic pair_valid,
  input wire logic pair_ready,
  output dppi_pkg::dppi_pair_type pair_data,
  output logic [10:0] pair_column_q,
  output logic [10:0] pair_row_q,
  output logic line_length_error_q,
  output logic frame_length_error_q,
  output logic overflow_q
);
  import dppi_pkg::*;
  // Two-stage synchronisers; stage one feeds only stage two
  logic [49:0] s1_q, s2_q;
  logic ck_prev_q;
  logic de_prev_q, de_prev_d;
  dppi_state_type st_q, st_d;
  logic [10:0] hclk_q, hclk_d;
  logic [10:0] hact_q, hact_d;
  logic [10:0] col_q, col_d;
  logic [10:0] row_q, row_d;
  logic [10:0] vline_q, vline_d;
  logic lerr_d, ferr_d, ovf_d;
  logic [10:0] pcol_d, prow_d;
  logic rise, de_s, push, f_ready;
  dppi_pair_type pair_in;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s1_q <= '0;
      s2_q <= '0;
      ck_prev_q <= 1'b0;
    end else begin
      s1_q <= {pixel_clock, pixel_window_strobe, odd_red_bits, odd_green_bits,
               odd_blue_bits, even_red_bits, even_green_bits, even_blue_bits};
      s2_q <= s1_q;
      ck_prev_q <= s2_q[49];
    end
  end
  // Data passes the same stages as the clock; the link must hold data around its edge
  assign rise = s2_q[49] && !ck_prev_q;
  assign de_s = s2_q[48];
  // Odd pixel in the upper half, bit order kept MSB..LSB
  assign pair_in = s2_q[47:0];
  assign push = rise && de_s;
  always_comb begin
    st_d = st_q;
    de_prev_d = de_prev_q;
    hclk_d = hclk_q;
    hact_d = hact_q;
    col_d = col_q;
    row_d = row_q;
    vline_d = vline_q;
    lerr_d = line_length_error_q;
    ferr_d = frame_length_error_q;
    ovf_d = overflow_q || (push && !f_ready);
    pcol_d = pair_column_q;
    prow_d = pair_row_q;
    if (rise) begin
      de_prev_d = de_s;
      // Horizontal counts are in link clocks
      hclk_d = (hclk_q == 11'h7ff) ? hclk_q : hclk_q + 11'h001;
      if (push) begin
        hact_d = hact_q + 11'h001;
        // Column of the odd pixel: 1, 3, 5 ...
        col_d = col_q + 11'h002;
        pcol_d = col_q;
        prow_d = row_q;
      end
      unique case (st_q)
        dppi_st_idle: begin
          if (de_s && !de_prev_q) begin
            st_d = dppi_st_line;
            hclk_d = 11'h001;
            hact_d = 11'h001;
            col_d = 11'h003;
            pcol_d = 11'h001;
            row_d = 11'h001;
            prow_d = 11'h001;
            vline_d = 11'h001;
          end
        end
        dppi_st_line: begin
          if (!de_s) begin
            st_d = dppi_st_blank;
            lerr_d = lerr_d || (hact_q != 11'(`DPPI_LINE_ACTIVE_CLK));
          end
        end
        dppi_st_blank: begin
          if (de_s) begin
            // Line ended: period check and new line, counted in lines
            st_d = dppi_st_line;
            lerr_d = lerr_d || (hclk_q < 11'(`DPPI_LINE_MIN_CLK))
                     || (hclk_q > 11'(`DPPI_LINE_MAX_CLK));
            hclk_d = 11'h001;
            hact_d = 11'h001;
            col_d = 11'h003;
            pcol_d = 11'h001;
            vline_d = vline_q + 11'h001;
            if (row_q == 11'(`DPPI_FRAME_ACTIVE_LINES)) begin
              // New frame; total line count judged here
              ferr_d = ferr_d || (vline_q < 11'(`DPPI_FRAME_MIN_LINES))
                       || (vline_q > 11'(`DPPI_FRAME_MAX_LINES));
              row_d = 11'h001;
              vline_d = 11'h001;
            end else begin
              row_d = row_q + 11'h001;
            end
            prow_d = row_d;
          end else if (hclk_q == 11'h7ff) begin
            // Long blank within the vertical interval counts whole lines
            hclk_d = 11'h000;
            vline_d = vline_q + 11'h001;
          end
        end
      endcase
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_q <= dppi_st_idle;
      de_prev_q <= 1'b0;
      hclk_q <= '0;
      hact_q <= '0;
      col_q <= '0;
      row_q <= '0;
      vline_q <= '0;
      line_length_error_q <= 1'b0;
      frame_length_error_q <= 1'b0;
      overflow_q <= 1'b0;
      pair_column_q <= '0;
      pair_row_q <= '0;
    end else begin
      st_q <= st_d;
      de_prev_q <= de_prev_d;
      hclk_q <= hclk_d;
      hact_q <= hact_d;
      col_q <= col_d;
      row_q <= row_d;
      vline_q <= vline_d;
      line_length_error_q <= lerr_d;
      frame_length_error_q <= ferr_d;
      overflow_q <= ovf_d;
      pair_column_q <= pcol_d;
      pair_row_q <= prow_d;
    end
  end
  // Full 8-bit words pass unaltered, so all 2^24 colours survive
  dppi_fifo #(
    .WIDTH(`DPPI_PAIR_W),
    .DEPTH(`DPPI_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .reset(reset),
    .in_valid(push),
    .in_ready(f_ready),
    .in_data(pair_in),
    .out_valid(pair_valid),
    .out_ready(pair_ready),
    .out_data(pair_data)
  );
endmodule : dppi_input

/* tb/dppi_input_monitor.sv */
// Checker on the pixel input outputs.
// Assumes bind onto dppi_input, one clock domain.
`timescale 1ns/1ns
module dppi_input_monitor (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic pair_valid,
  input wire logic pair_ready,
  input wire dppi_pkg::dppi_pair_type pair_data,
  input wire logic [10:0] pair_column_q,
  input wire logic [10:0] pair_row_q,
  input wire logic overflow_q
);
  import dppi_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  property p_hold;
    pair_valid && !pair_ready |=> pair_valid && $stable(pair_data);
  endproperty
  a_hold: assert property (p_hold) else $error("stalled pair moved");
  property p_odd;
    $changed(pair_column_q) |-> pair_column_q[0];
  endproperty
  a_odd: assert property (p_odd) else $error("even column");
  // A drop skips columns, so the step is only judged before overflow
  property p_step;
    $changed(pair_column_q) && pair_column_q != 11'h001 && !overflow_q
      |-> pair_column_q == $past(pair_column_q) + 11'h002;
  endproperty
  a_step: assert property (p_step) else $error("column step");
  property p_row;
    $changed(pair_column_q) && pair_column_q == 11'h001
      |-> pair_row_q == $past(pair_row_q) + 11'h001 || pair_row_q == 11'h001;
  endproperty
  a_row: assert property (p_row) else $error("row step");
  property p_rmax;
    pair_row_q <= 11'h400;
  endproperty
  a_rmax: assert property (p_rmax) else $error("row range");
endmodule : dppi_input_monitor
bind dppi_input dppi_input_monitor i_mon (.clk_sys(clk_sys), .reset(reset),
  .pair_valid(pair_valid), .pair_ready(pair_ready), .pair_data(pair_data),
  .pair_column_q(pair_column_q), .pair_row_q(pair_row_q), .overflow_q(overflow_q));

/* tb/dppi_host_model.sv */
// Host model: one line of link clocks per go, strobe first.
// Assumes go rises once per line and busy is awaited.
`timescale 1ns/1ns
module dppi_host_model (
  input wire logic go,
  input wire logic [10:0] span,
  input wire logic [10:0] active,
  output logic busy,
  output logic pixel_clock,
  output logic strobe,
  output dppi_pkg::dppi_pair_type pix
);
  import dppi_pkg::*;
  initial begin
    busy = 0;
    pixel_clock = 0;
    strobe = 0;
    pix = 48'h0;
  end
  // Data changes every clock, blanking too, so a stale sample never matches
  always @(posedge go) begin
    busy = 1;
    for (int i = 0; i < span; i++) begin
      strobe = (i < active);
      pix = 48'({$urandom, $urandom});
      #62 pixel_clock = 1;
      #63 pixel_clock = 0;
    end
    strobe = 0;
    pix = ~pix;
    busy = 0;
  end
endmodule : dppi_host_model

/* tb/dppi_input_test.sv */
// Bench for the pixel input: host lines, random stalls, queued compares.
// Assumes the host model and the checker compiled alongside.
`timescale 1ns/1ns
`include "dppi_consts.svh"
module dppi_input_test;
  import dppi_pkg::*;
  logic clk_sys = 0, reset = 1, pair_ready = 0, go = 0, stall = 0;
  logic pclk, strobe, busy, pair_valid, lerr, ferr, ovf;
  logic [10:0] col, row, span = 0, active = 0;
  dppi_pair_type pix, pair_data, exp_q[$];
  int mismatches = 0, checked = 0, n, k = 0;
  always #5 clk_sys = ~clk_sys;
  dppi_host_model i_host (.go(go), .span(span), .active(active), .busy(busy),
    .pixel_clock(pclk), .strobe(strobe), .pix(pix));
  dppi_input i_dut (.clk_sys(clk_sys), .reset(reset), .pixel_clock(pclk),
    .pixel_window_strobe(strobe), .odd_red_bits(pix[47:40]), .odd_green_bits(pix[39:32]),
    .odd_blue_bits(pix[31:24]), .even_red_bits(pix[23:16]), .even_green_bits(pix[15:8]),
    .even_blue_bits(pix[7:0]), .pair_valid(pair_valid), .pair_ready(pair_ready),
    .pair_data(pair_data), .pair_column_q(col), .pair_row_q(row),
    .line_length_error_q(lerr), .frame_length_error_q(ferr), .overflow_q(ovf));
  task automatic check(string what, logic [47:0] exp, logic [47:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic results();
    if (mismatches == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  task automatic line(int s, int a);
    @(posedge clk_sys);
    #1 span = 11'(s);
    active = 11'(a);
    go = 1;
    @(posedge clk_sys);
    #1 go = 0;
    n = 0;
    while (busy && n < 20000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 20000) begin
      mismatches++;
      results();
    end
  endtask : line
  always @(posedge pclk) if (strobe) exp_q.push_back(pix);
  always @(posedge clk_sys) pair_ready <= #1 !stall && $urandom_range(3) != 0;
  always @(posedge clk_sys) begin
    if (pair_valid && pair_ready) begin
      if (exp_q.size() == 0) check("spare pair", 48'h0, 48'h1);
      else check("pair_data", exp_q.pop_front(), pair_data);
    end
  end
  initial begin
    n = $urandom(32'hb0326241);
    repeat (20) @(posedge clk_sys);
    #1 reset = 0;
    line(844, 640);
    repeat (20) @(posedge clk_sys);
    check("row", 48'h1, 48'(row));
    check("column", 48'h4ff, 48'(col));
    check("line error", 48'h0, 48'(lerr));
    check("frame error", 48'h0, 48'(ferr));
    check("left", 48'h0, 48'(exp_q.size()));
    // Stalled short line: the output register and eight memory words keep the
    // first pairs, later ones drop, so only those notes stay expected
    #1 stall = 1;
    line(700, 20);
    check("overflow", 48'h1, 48'(ovf));
    check("line error", 48'h1, 48'(lerr));
    while (exp_q.size() > `DPPI_FIFO_DEPTH + 1) exp_q.delete(exp_q.size() - 1);
    #1 stall = 0;
    for (int i = 0; i < 60; i++) begin
      @(posedge clk_sys);
      if (pair_valid && pair_ready) k++;
    end
    check("drained", 48'(`DPPI_FIFO_DEPTH + 1), 48'(k));
    check("empty", 48'h0, 48'(pair_valid));
    check("left", 48'h0, 48'(exp_q.size()));
    line(700, 640);
    repeat (20) @(posedge clk_sys);
    check("left", 48'h0, 48'(exp_q.size()));
    check("row", 48'h3, 48'(row));
    check("line error", 48'h1, 48'(lerr));
    results();
  end
endmodule : dppi_input_test
